/* File: design/pee_pkg.sv */
// Purpose: Shared constants and types for the port EEE status register group
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes: Register indices are multiplied by four to form byte addresses
package pee_pkg;

  // Register indices and their byte addresses (index times four)
  localparam logic [9:0] PEE_IDX_ADV = 10'h0ec;
  localparam logic [9:0] PEE_IDX_WEC = 10'h0ee;
  localparam logic [9:0] PEE_IDX_CS = 10'h0f0;
  localparam logic [11:0] PEE_ADDR_ADV = {PEE_IDX_ADV, 2'h0};
  localparam logic [11:0] PEE_ADDR_WEC = {PEE_IDX_WEC, 2'h0};
  localparam logic [11:0] PEE_ADDR_CS = {PEE_IDX_CS, 2'h0};

  // Field positions
  localparam int unsigned PEE_ADV_LP_LSB = 9;
  localparam int unsigned PEE_ADV_LP_MSB = 14;
  localparam int unsigned PEE_ADV_100TX_BIT = 1;
  localparam int unsigned PEE_CS_RSV_BIT = 15;
  localparam int unsigned PEE_CS_HW_EN_BIT = 14;
  localparam int unsigned PEE_CS_TX_LATCH_BIT = 13;
  localparam int unsigned PEE_CS_TX_LIVE_BIT = 12;

  // Reset values
  localparam logic PEE_ADV_100TX_RST = 1'h1;
  localparam logic PEE_CS_RSV_RST = 1'h1;
  localparam logic PEE_TX_LATCH_RST = 1'h0;
  localparam logic [15:0] PEE_WEC_RST = 16'h0000;
  localparam logic [15:0] PEE_WEC_MAX = 16'hffff;

  // Status arriving from the port's PHY and PCS
  typedef struct packed {
    logic fiber_mode;
    logic [5:0] lp_eee_cap;
    logic hw_eee_en;
    logic tx_lpi;
    logic wake_timer_done;
  } pee_phy_type;

endpackage : pee_pkg

/* File: design/pee_wake_counter.sv */
// Purpose: Saturating 16-bit wake error counter with clear on read
// Assumes: inc and clr are single-cycle pulses on hclk
// Notes: A wake error in the clear cycle is kept as a count of one
`timescale 1ns/1ps
`default_nettype none
module pee_wake_counter (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic inc,
  input wire logic clr,
  output var logic [15:0] count
);
  import pee_pkg::*;

  logic [15:0] next_count;
  logic at_max;

  // Hold at all ones rather than wrapping, so software sees overflow
  assign at_max = (count == PEE_WEC_MAX);
  assign next_count = clr ? {15'h0000, inc} :
                      (inc && !at_max) ? count + 16'h0001 : count;

  // Counter register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= PEE_WEC_RST;
    end else begin
      count <= next_count;
    end
  end

endmodule : pee_wake_counter
`default_nettype wire

/* File: design/pee_regs.sv */
// Purpose: Port EEE advertisement, wake error count and control/status registers
// Assumes: AHB-Lite slave, zero wait states, PHY status arrives asynchronously
// Notes: Read data is captured at the address phase edge; writes land in the data phase
//
// Functional notes
// - No EEE advertisement to the PHY, wake counting or new LPI status while port is fiber; a set latch holds.
// - Bits 14..9 show link partner EEE capability, reset to zero.
// - Local advertisement bits 6..2 are read-only zero.
// - Advertisement bit 1 (100BASE-TX) is writable, resets to one.
// - Wake counter increments on each rising edge of wake timer done.
// - Wake counter saturates at all ones.
// - Reading the wake counter returns its value then clears it.
// - Status bit 14 shows hardware 100BASE-TX EEE enable, resets zero.
// - Status bit 13 latches high when transmit LPI is seen.
// - Latched transmit LPI clears only by writing one to it.
// - Status bit 12 follows live transmit LPI, unlatched.
`timescale 1ns/1ps
`default_nettype none
module pee_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output var logic hreadyout,
  output var logic hresp,
  output var logic [31:0] hrdata,
  input wire pee_pkg::pee_phy_type phy_status,
  output var logic eee_adv_100tx
);
  import pee_pkg::*;

  // Synchroniser stages; stage one is read only by stage two
  pee_phy_type sync1;
  pee_phy_type sync2;
  logic wake_prev;

  // Register state
  logic adv_100tx;
  logic cs_rsv;
  logic tx_latch;
  logic wr_adv;
  logic wr_cs;
  logic [15:0] wec_count;

  // Bus decode
  logic addr_phase;
  logic rd_req;
  logic sel_adv;
  logic sel_wec;
  logic sel_cs;
  logic copper;
  logic wake_rise;
  logic tx_clr;
  logic next_adv_100tx;
  logic next_cs_rsv;
  logic next_tx_latch;
  logic [15:0] adv_word;
  logic [15:0] cs_word;
  logic [15:0] rd_word;

  // Two-flop crossing of the PHY status, plus one stage for edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      wake_prev <= 1'h0;
    end else begin
      sync1 <= phy_status;
      sync2 <= sync1;
      wake_prev <= sync2.wake_timer_done;
    end
  end

  // Address phase decode; hsize is ignored since only whole words are used
  assign addr_phase = hsel && htrans[1] && hready;
  assign rd_req = addr_phase && !hwrite;
  assign sel_adv = (haddr[11:0] == PEE_ADDR_ADV);
  assign sel_wec = (haddr[11:0] == PEE_ADDR_WEC);
  assign sel_cs = (haddr[11:0] == PEE_ADDR_CS);

  // EEE is a copper-only feature
  assign copper = !sync2.fiber_mode;
  assign wake_rise = sync2.wake_timer_done && !wake_prev && copper;

  // Next register values; forwarded into read data so read-after-write is fresh
  assign next_adv_100tx = wr_adv ? hwdata[PEE_ADV_100TX_BIT] : adv_100tx;
  assign next_cs_rsv = wr_cs ? hwdata[PEE_CS_RSV_BIT] : cs_rsv;
  assign tx_clr = wr_cs && hwdata[PEE_CS_TX_LATCH_BIT];
  // A new LPI event beats a clear in the same cycle
  assign next_tx_latch = (sync2.tx_lpi && copper) || (tx_latch && !tx_clr);

  // Read words; bits not built here read zero
  assign adv_word = {1'h0,
                     sync2.lp_eee_cap,
                     2'h0,
                     5'h00,
                     next_adv_100tx,
                     1'h0};
  assign cs_word = {next_cs_rsv,
                    sync2.hw_eee_en && copper,
                    next_tx_latch,
                    sync2.tx_lpi && copper,
                    12'h000};
  assign rd_word = sel_adv ? adv_word :
                   sel_wec ? wec_count :
                   sel_cs ? cs_word : 16'h0000;

  // Saturating wake error counter, cleared by a read of its word
  pee_wake_counter u_wake (
    .hclk(hclk),
    .hresetn(hresetn),
    .inc(wake_rise),
    .clr(rd_req && sel_wec),
    .count(wec_count)
  );

  // Bus side: capture read data and write intent at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'h1;
      hresp <= 1'h0;
      hrdata <= 32'h00000000;
      wr_adv <= 1'h0;
      wr_cs <= 1'h0;
    end else begin
      hreadyout <= 1'h1;
      hresp <= 1'h0;
      wr_adv <= addr_phase && hwrite && sel_adv;
      wr_cs <= addr_phase && hwrite && sel_cs;
      if (rd_req) begin
        hrdata <= {16'h0000, rd_word};
      end
    end
  end

  // Register updates in the write data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adv_100tx <= PEE_ADV_100TX_RST;
      cs_rsv <= PEE_CS_RSV_RST;
      tx_latch <= PEE_TX_LATCH_RST;
      eee_adv_100tx <= 1'h0;
    end else begin
      adv_100tx <= next_adv_100tx;
      cs_rsv <= next_cs_rsv;
      tx_latch <= next_tx_latch;
      // Advertisement to the PHY is withheld in fiber mode
      eee_adv_100tx <= next_adv_100tx && copper;
    end
  end

  // Fiber mode never counts wake errors
  chk_fiber_no_count: assert property (@(posedge hclk) disable iff (!hresetn)
    (sync2.fiber_mode && !(rd_req && sel_wec)) |=> (wec_count == $past(wec_count)))
    else $error("wake counter moved in fiber mode");

  // Partner capability bits appear on a read of the advertisement word
  chk_lp_cap_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_req && sel_adv) |=> (hrdata[14:9] == $past(sync2.lp_eee_cap)))
    else $error("partner capability not reported");

  // Local high-speed advertisement bits are zero, reserved bits too
  chk_adv_ro_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_req && sel_adv) |=> (hrdata[8:2] == 7'h00) && !hrdata[0] && !hrdata[15])
    else $error("read-only advertisement bits not zero");

  // A write to the advertisement word reaches the bit 1 register
  chk_adv_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_adv |=> (adv_100tx == $past(hwdata[1])))
    else $error("advertisement bit not written");

  // A rising wake event below saturation adds exactly one
  chk_wake_incr: assert property (@(posedge hclk) disable iff (!hresetn)
    (wake_rise && !(rd_req && sel_wec) && wec_count != 16'hffff)
      |=> (wec_count == $past(wec_count) + 16'h0001))
    else $error("wake counter did not increment");

  // Saturated counter stays at all ones
  chk_wake_sat: assert property (@(posedge hclk) disable iff (!hresetn)
    (wec_count == 16'hffff && !(rd_req && sel_wec)) |=> (wec_count == 16'hffff))
    else $error("wake counter wrapped");

  // Reading returns the count and clears it
  chk_wake_rdclr: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_req && sel_wec && !wake_rise)
      |=> (wec_count == 16'h0000) && (hrdata[15:0] == $past(wec_count)))
    else $error("wake counter read clear failed");

  // Hardware enable status tracks the synchronised input on copper
  chk_hw_en_status: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_req && sel_cs) |=> (hrdata[14] == $past(sync2.hw_eee_en && copper)))
    else $error("hardware enable status wrong");

  // Latched LPI holds unless a one is written to it
  chk_tx_latch_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_latch && !tx_clr) |=> tx_latch)
    else $error("latched LPI dropped without clear");

  // Live LPI on copper sets the latch next cycle
  chk_tx_latch_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (sync2.tx_lpi && copper) |=> tx_latch)
    else $error("latched LPI not set");

  // Live LPI bit is unlatched
  chk_tx_live: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_req && sel_cs) |=> (hrdata[12] == $past(sync2.tx_lpi && copper)))
    else $error("live LPI bit wrong");

  // Read data carries the forwarded bit, so a read right after a write is fresh
  chk_adv_read_back: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_req && sel_adv) |=> (hrdata[PEE_ADV_100TX_BIT] == adv_100tx))
    else $error("advertisement bit read back wrong");

  // Only a write data phase may move the advertisement bit
  chk_adv_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_adv |=> $stable(adv_100tx))
    else $error("advertisement bit moved without a write");

  // On copper the PHY sees a written advertisement in the same edge as the register
  chk_adv_out_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_adv && copper)
      |=> (eee_adv_100tx == $past(hwdata[PEE_ADV_100TX_BIT])))
    else $error("advertisement not passed to the PHY");

  // Fiber withholds the advertisement whatever software has written
  chk_adv_out_fiber: assert property (@(posedge hclk) disable iff (!hresetn)
    !copper |=> !eee_adv_100tx)
    else $error("advertisement sent in fiber mode");

  // Without an event or a read the count must not drift
  chk_no_wake_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    (!wake_rise && !(rd_req && sel_wec)) |=> $stable(wec_count))
    else $error("wake counter moved without an event");

  // A level held high counts once; the edge detector must not refire
  chk_wake_single: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_rise |=> !wake_rise)
    else $error("wake edge detected twice");

  // An event in the read-clear cycle is kept, so the clear never loses a wake error
  chk_wake_rd_event: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_req && sel_wec && wake_rise) |=> (wec_count == 16'h0001))
    else $error("wake event lost in read clear");

  // Software cannot preload the counter; writes to its word are dropped
  chk_wec_no_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_phase && hwrite && sel_wec && !wake_rise) |=> $stable(wec_count))
    else $error("wake counter took a write");

  // Read data stands until the next read, so a slow master still sees it
  chk_hrdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !rd_req |=> $stable(hrdata))
    else $error("read data changed without a read");

  // Unmapped words read zero and cost nothing on the bus
  chk_unmapped_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_req && !sel_adv && !sel_wec && !sel_cs)
      |=> (hrdata == 32'h00000000))
    else $error("unmapped word not zero");

  // Registers are 16 bits wide; the upper half of the bus stays zero
  chk_rdata_upper: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req |=> (hrdata[31:16] == 16'h0000))
    else $error("upper read half not zero");

  // Low status bits are not built in this block and read zero
  chk_cs_low_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_req && sel_cs) |=> (hrdata[11:0] == 12'h000))
    else $error("low status bits not zero");

  // The latched bit read matches the latch after the same edge
  chk_cs_latch_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_req && sel_cs) |=> (hrdata[PEE_CS_TX_LATCH_BIT] == tx_latch))
    else $error("latched LPI read wrong");

  // A one written to the latch clears it when no new LPI arrives
  chk_tx_latch_clr: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_clr && !(sync2.tx_lpi && copper)) |=> !tx_latch)
    else $error("latched LPI not cleared");

  // Fiber never sets the latch, even with LPI present on the input
  chk_tx_latch_fiber: assert property (@(posedge hclk) disable iff (!hresetn)
    (!tx_latch && !copper) |=> !tx_latch)
    else $error("latched LPI set in fiber mode");

  // Fiber hides hardware enable and live LPI from software
  chk_status_fiber: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_req && sel_cs && !copper)
      |=> (!hrdata[PEE_CS_HW_EN_BIT] && !hrdata[PEE_CS_TX_LIVE_BIT]))
    else $error("status shown in fiber mode");

  // Fiber suppresses the wake edge itself, not only the count
  chk_wake_fiber: assert property (@(posedge hclk) disable iff (!hresetn)
    !copper |-> !wake_rise)
    else $error("wake edge seen in fiber mode");

endmodule : pee_regs
`default_nettype wire

/* File: test/tb.sv */
// Purpose: Self-checking bench for the port EEE status register group
// Assumes: Zero-wait AHB-Lite slave; PHY status takes about 3 cycles to show
// Notes: Saturation needs 64k wake events and stays with the design's own checks
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pee_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hresp, eee_adv_100tx;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  pee_phy_type phy;
  int num_errors = 0;
  int n_compared = 0;

  // The slave's hreadyout is the bus hready
  pee_regs u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .phy_status(phy),
    .eee_adv_100tx(eee_adv_100tx));

  // 200 MHz clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One single transfer; read data taken at the data phase's closing edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    // Only the watchdog ends a wait for the slave
    while (hready !== 1'b1) begin
      @(posedge hclk);
    end
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      @(posedge hclk);
    end
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rd_chk

  // Long enough for the synchroniser and edge detector
  task automatic settle;
    repeat (5) @(posedge hclk);
  endtask : settle

  // Wide pulse so the two-flop synchroniser cannot miss it
  task automatic wake_pulse;
    @(posedge hclk);
    phy.wake_timer_done <= 1'b1;
    repeat (3) @(posedge hclk);
    phy.wake_timer_done <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask : wake_pulse

  // The PHY output leaves its reset value one edge after release, so look after a read
  task automatic t_reset;
    rd_chk(PEE_ADDR_ADV, 32'h2);
    check({31'h0, eee_adv_100tx}, 32'h1);
    rd_chk(PEE_ADDR_CS, 32'h8000);
    rd_chk(PEE_ADDR_WEC, 32'h0);
    rd_chk(12'h3b4, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_adv;
    bus(1'b1, PEE_ADDR_ADV, 32'hfffffffd);
    rd_chk(PEE_ADDR_ADV, 32'h0);
    check({31'h0, eee_adv_100tx}, 32'h0);
    bus(1'b1, PEE_ADDR_ADV, 32'h2);
    rd_chk(PEE_ADDR_ADV, 32'h2);
    // Walk each partner capability across its own bit
    for (int i = 0; i < 6; i++) begin
      phy.lp_eee_cap <= 6'h01 << i;
      settle();
      rd_chk(PEE_ADDR_ADV, (32'h200 << i) | 32'h2);
    end
    phy.lp_eee_cap <= 6'h00;
    $display("test advertisement done");
  endtask : t_adv

  task automatic t_wake;
    repeat (3) wake_pulse();
    settle();
    rd_chk(PEE_ADDR_WEC, 32'h3);
    rd_chk(PEE_ADDR_WEC, 32'h0);
    wake_pulse();
    settle();
    bus(1'b1, PEE_ADDR_WEC, 32'h1234);
    rd_chk(PEE_ADDR_WEC, 32'h1);
    rd_chk(PEE_ADDR_WEC, 32'h0);
    $display("test wake counter done");
  endtask : t_wake

  task automatic t_lpi;
    phy.hw_eee_en <= 1'b1;
    phy.tx_lpi <= 1'b1;
    settle();
    rd_chk(PEE_ADDR_CS, 32'hf000);
    phy.tx_lpi <= 1'b0;
    settle();
    rd_chk(PEE_ADDR_CS, 32'he000);
    rd_chk(PEE_ADDR_CS, 32'he000);
    bus(1'b1, PEE_ADDR_CS, 32'h8fff);
    rd_chk(PEE_ADDR_CS, 32'he000);
    bus(1'b1, PEE_ADDR_CS, 32'ha000);
    rd_chk(PEE_ADDR_CS, 32'hc000);
    // Withdrawing the advertisement alone leaves the negotiated enable standing
    bus(1'b1, PEE_ADDR_ADV, 32'h0);
    rd_chk(PEE_ADDR_CS, 32'hc000);
    bus(1'b1, PEE_ADDR_ADV, 32'h2);
    $display("test lpi status done");
  endtask : t_lpi

  task automatic t_fiber;
    phy.fiber_mode <= 1'b1;
    settle();
    phy.tx_lpi <= 1'b1;
    wake_pulse();
    settle();
    check({31'h0, eee_adv_100tx}, 32'h0);
    rd_chk(PEE_ADDR_CS, 32'h8000);
    rd_chk(PEE_ADDR_WEC, 32'h0);
    phy.tx_lpi <= 1'b0;
    settle();
    phy.fiber_mode <= 1'b0;
    settle();
    check({31'h0, eee_adv_100tx}, 32'h1);
    $display("test fiber done");
  endtask : t_fiber

  task automatic report_and_stop;
    $display("compared=%0d errors=%0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge hclk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    phy = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_adv();
    t_wake();
    t_lpi();
    t_fiber();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
